// ### rtl/rsf_map.svh
// register offsets, reset values, command codes and reply characters
// assumes byte addresses on a 32-bit avalon-mm slave
`ifndef RSF_MAP_SVH
`define RSF_MAP_SVH
`define RSF_OFF_SERIAL   8'h00
`define RSF_OFF_APPEND   8'h04
`define RSF_OFF_PROTO    8'h08
`define RSF_OFF_IO       8'h0c
`define RSF_OFF_RADIO    8'h10
`define RSF_OFF_PRES     8'h14
`define RSF_OFF_FILTER   8'h18
`define RSF_OFF_CARD     8'h1c
`define RSF_OFF_CMD      8'h20
`define RSF_OFF_STATUS   8'h24
`define RSF_OFF_DATA     8'h28
`define RSF_RST_SERIAL   6'h05
`define RSF_RST_APPEND   3'h0
`define RSF_RST_PROTO    12'h3fc
`define RSF_RST_IO       7'h00
`define RSF_RST_RADIO    29'h0000002
`define RSF_RST_PRES     8'h78
`define RSF_RST_FILTER   5'h00
`define RSF_RST_CARD     9'h002
`define RSF_CMD_SERIAL   16'h020a
`define RSF_CMD_APPEND   16'h020c
`define RSF_CMD_PROTO    16'h020d
`define RSF_CMD_IO       16'h020e
`define RSF_CMD_RADIO    16'h020f
`define RSF_CMD_PRES     16'h0211
`define RSF_CMD_FILTER   16'h0212
`define RSF_CMD_CARD     16'h0214
`define RSF_CMD_RETX     16'h0215
`define RSF_LEN_SERIAL   6'h11
`define RSF_LEN_APPEND   6'h0e
`define RSF_LEN_PROTO    6'h12
`define RSF_LEN_IO       6'h11
`define RSF_LEN_RADIO    6'h23
`define RSF_LEN_RADIO_L  6'h22
`define RSF_LEN_PRES     6'h14
`define RSF_LEN_FILTER   6'h0b
`define RSF_LEN_CARD     6'h06
`define RSF_LEN_RETX     6'h07
`define RSF_TAG_SERIAL   32'h4d41494e
`define RSF_TAG_APPEND   32'h49444150
`define RSF_TAG_PROTO    32'h45435053
`define RSF_TAG_IO       32'h494f5354
`define RSF_TAG_RADIO    32'h52465354
`define RSF_TAG_PRES     32'h50525354
`define RSF_TAG_FILTER   32'h52463053
`define RSF_TAG_CARD     24'h543046
`define RSF_TAG_RETX     24'h575449
`define RSF_CH_SP        8'h20
`define RSF_CH_ZERO      8'h30
`define RSF_CH_CR        8'h0d
`define RSF_CH_A         8'h41
`define RSF_CH_B         8'h42
`define RSF_CH_C         8'h43
`define RSF_CH_D         8'h44
`define RSF_CH_F         8'h46
`define RSF_CH_G         8'h47
`define RSF_CH_I         8'h49
`define RSF_CH_O         8'h4f
`define RSF_CH_P         8'h50
`define RSF_CH_R         8'h52
`define RSF_CH_S         8'h53
`define RSF_CH_T         8'h54
`define RSF_CH_U         8'h55
`define RSF_CH_V         8'h56
`define RSF_CH_X         8'h58
`define RSF_HUNDRED      7'h64
`define RSF_TEN          7'h0a
`endif

// ### rtl/rsf_pkg.sv
// setting field layouts and formatter state type
// assumes the map header supplies offsets and reset values
package rsf_pkg;
   typedef struct packed {
      logic [1:0] parity;
      logic       stop;
      logic [2:0] baud;
   } rsf_serial_t;
   typedef struct packed {
      logic aux;
      logic date;
      logic time_f;
   } rsf_append_t;
   typedef struct packed {
      logic [1:0] flow;
      logic [7:0] timeout;
      logic [1:0] mode;
   } rsf_proto_t;
   typedef struct packed {
      logic [3:0] pulse;
      logic [1:0] outs;
      logic       ctl;
   } rsf_io_t;
   typedef struct packed {
      logic [3:0] atten3;
      logic [3:0] atten;
      logic [4:0] range_b;
      logic [4:0] range_a;
      logic       legacy;
      logic [6:0] freq;
      logic [1:0] dup;
      logic       ctl;
   } rsf_radio_t;
   typedef struct packed {
      logic       invert;
      logic [3:0] timeout;
      logic [1:0] turnoff;
      logic       no_tag;
   } rsf_pres_t;
   typedef struct packed {
      logic [1:0] valid;
      logic [2:0] sep;
   } rsf_filter_t;
   typedef struct packed {
      logic [7:0] interval;
      logic       en;
   } rsf_card_t;
   typedef enum logic {rsf_st_idle, rsf_st_build} rsf_state_t;
endpackage

// ### rtl/rsf_formatter.sv
// status reply formatter: builds ascii replies for display commands
// assumes an avalon-mm master with waitrequest and a synchronous io_in
// Functional notes
// - command 522 reports baud B2-B7, stop S0/S1, parity P0-P2
// - serial reply always ends with line-end delay field D0
// - command 524 reports time, date, aux append flags as 0 or 1
// - command 525 reports protocol P0-P2 and start-of-message field S0
// - protocol reply gives timeout as two hex digits, FF disabled
// - protocol reply gives flow control X0, X1 or X2
// - command 526 reports output control C0 host or C1 automatic
// - io reply gives output state O0 to O3
// - io reply gives input state I0 to I3
// - io reply gives one hex digit pulse width code
// - command 527 reports radio control C0/C1 and radio state O0/O1
// - radio reply gives duplicate timeout code T1 to T3
// - radio reply gives frequency as three decimal digits 000-118
// - radio reply gives two decoder ranges as two hex digits each
// - radio reply gives power attenuation and third-protocol attenuation
// - legacy entry makes the frequency field two digits wide
// - command 529 reports no-tag presence P0/P1 and fixed D0 field
// - presence reply gives radio turn-off condition A0 to A2
// - presence reply gives one hex digit radio timeout code
// - presence reply gives input inversion I0 or I1
// - command 530 reports id separation U0-U4 and valid criteria V0-V3
// - commands 532 and 533 report card output mode and interval
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "rsf_map.svh"
module rsf_formatter #(
   parameter int ML = 36
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic [1:0]  io_in,
   input  wire logic        rf_on
);
   localparam int BW = 8 * ML;
   rsf_pkg::rsf_serial_t serial_r;
   rsf_pkg::rsf_append_t append_r;
   rsf_pkg::rsf_proto_t  proto_r;
   rsf_pkg::rsf_io_t     io_r;
   rsf_pkg::rsf_radio_t  radio_r;
   rsf_pkg::rsf_pres_t   pres_r;
   rsf_pkg::rsf_filter_t filter_r;
   rsf_pkg::rsf_card_t   card_r;
   rsf_pkg::rsf_state_t  st_r;
   logic [15:0]          cmd_r;
   logic [BW-1:0]        buf_r;
   logic [5:0]           len_r;
   logic                 err_r;
   logic                 wait_r;
   logic [31:0]          rdata_r;

   function automatic logic [7:0] hexc(input logic [3:0] v);
      hexc = (v < 4'ha) ? (`RSF_CH_ZERO + {4'h0, v}) : (`RSF_CH_A + {4'h0, v} - 8'h0a);
   endfunction

   // bus handshake: one wait cycle, then the transfer completes
   wire req       = read | write;
   wire commit    = req & ~wait_r;
   wire wr_commit = commit & write;
   wire rd_commit = commit & read;
   wire sel_ser   = address == `RSF_OFF_SERIAL;
   wire sel_app   = address == `RSF_OFF_APPEND;
   wire sel_pro   = address == `RSF_OFF_PROTO;
   wire sel_io    = address == `RSF_OFF_IO;
   wire sel_rad   = address == `RSF_OFF_RADIO;
   wire sel_pre   = address == `RSF_OFF_PRES;
   wire sel_fil   = address == `RSF_OFF_FILTER;
   wire sel_crd   = address == `RSF_OFF_CARD;
   wire sel_cmd   = address == `RSF_OFF_CMD;
   wire sel_sta   = address == `RSF_OFF_STATUS;
   wire sel_dat   = address == `RSF_OFF_DATA;
   wire pop       = rd_commit & sel_dat & (len_r != 6'h00) & (st_r == rsf_pkg::rsf_st_idle);

   wire [31:0] rd_mux =
      sel_ser ? {26'h0, serial_r} :
      sel_app ? {29'h0, append_r} :
      sel_pro ? {20'h0, proto_r} :
      sel_io  ? {25'h0, io_r} :
      sel_rad ? {3'h0, radio_r} :
      sel_pre ? {24'h0, pres_r} :
      sel_fil ? {27'h0, filter_r} :
      sel_crd ? {23'h0, card_r} :
      sel_cmd ? {16'h0, cmd_r} :
      sel_sta ? {24'h0, (st_r == rsf_pkg::rsf_st_build), err_r, len_r} :
      (sel_dat && len_r != 6'h00) ? {24'h0, buf_r[BW-1 -: 8]} :
      32'h0;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0;
      end else if (req && wait_r) begin
         wait_r  <= 1'b0;
         rdata_r <= rd_mux;
      end else begin
         wait_r  <= 1'b1;
      end
   end
   assign waitrequest = wait_r;
   assign readdata    = rdata_r;

   // settings written by software steer the reply contents
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_r <= `RSF_RST_SERIAL;
         append_r <= `RSF_RST_APPEND;
         proto_r  <= `RSF_RST_PROTO;
         io_r     <= `RSF_RST_IO;
         radio_r  <= `RSF_RST_RADIO;
         pres_r   <= `RSF_RST_PRES;
         filter_r <= `RSF_RST_FILTER;
         card_r   <= `RSF_RST_CARD;
      end else if (wr_commit) begin
         if (sel_ser) serial_r <= rsf_pkg::rsf_serial_t'(writedata[5:0]);
         if (sel_app) append_r <= rsf_pkg::rsf_append_t'(writedata[2:0]);
         if (sel_pro) proto_r  <= rsf_pkg::rsf_proto_t'(writedata[11:0]);
         if (sel_io)  io_r     <= rsf_pkg::rsf_io_t'(writedata[6:0]);
         if (sel_rad) radio_r  <= rsf_pkg::rsf_radio_t'(writedata[28:0]);
         if (sel_pre) pres_r   <= rsf_pkg::rsf_pres_t'(writedata[7:0]);
         if (sel_fil) filter_r <= rsf_pkg::rsf_filter_t'(writedata[4:0]);
         if (sel_crd) card_r   <= rsf_pkg::rsf_card_t'(writedata[8:0]);
      end
   end

   // serial port reply
   wire [8*17-1:0] t522 = {
      `RSF_TAG_SERIAL,
      `RSF_CH_SP, `RSF_CH_B, hexc({1'b0, serial_r.baud}),
      `RSF_CH_SP, `RSF_CH_S, hexc({3'h0, serial_r.stop}),
      `RSF_CH_SP, `RSF_CH_P, hexc({2'h0, serial_r.parity}),
      `RSF_CH_SP, `RSF_CH_D, `RSF_CH_ZERO,
      `RSF_CH_CR};

   // append flags reply
   wire [8*14-1:0] t524 = {
      `RSF_TAG_APPEND,
      `RSF_CH_SP, `RSF_CH_T, hexc({3'h0, append_r.time_f}),
      `RSF_CH_SP, `RSF_CH_D, hexc({3'h0, append_r.date}),
      `RSF_CH_SP, `RSF_CH_X, hexc({3'h0, append_r.aux}),
      `RSF_CH_CR};

   // host protocol reply
   wire [8*18-1:0] t525 = {
      `RSF_TAG_PROTO,
      `RSF_CH_SP, `RSF_CH_P, hexc({2'h0, proto_r.mode}),
      `RSF_CH_SP, `RSF_CH_T,
      hexc(proto_r.timeout[7:4]),
      hexc(proto_r.timeout[3:0]),
      `RSF_CH_SP, `RSF_CH_X, hexc({2'h0, proto_r.flow}),
      `RSF_CH_SP, `RSF_CH_S, `RSF_CH_ZERO,
      `RSF_CH_CR};

   // discrete io reply
   wire [8*17-1:0] t526 = {
      `RSF_TAG_IO,
      `RSF_CH_SP, `RSF_CH_C, hexc({3'h0, io_r.ctl}),
      `RSF_CH_SP, `RSF_CH_O, hexc({2'h0, io_r.outs}),
      `RSF_CH_SP, `RSF_CH_I, hexc({2'h0, io_in}),
      `RSF_CH_SP, `RSF_CH_D, hexc(io_r.pulse),
      `RSF_CH_CR};

   // frequency split into decimal digits, only 0..127 fits the field
   wire       f_hund = radio_r.freq >= `RSF_HUNDRED;
   wire [6:0] f_rem  = radio_r.freq - (f_hund ? `RSF_HUNDRED : 7'h00);
   wire [6:0] f_tens = f_rem / `RSF_TEN;
   wire [6:0] f_ones = f_rem % `RSF_TEN;

   // radio reply, head and tail shared by both frequency forms
   wire [8*13-1:0] rf_head = {
      `RSF_TAG_RADIO,
      `RSF_CH_SP, `RSF_CH_C, hexc({3'h0, radio_r.ctl}),
      `RSF_CH_SP, `RSF_CH_O, hexc({3'h0, rf_on}),
      `RSF_CH_SP, `RSF_CH_T, hexc({2'h0, radio_r.dup})};
   wire [8*17-1:0] rf_tail = {
      `RSF_CH_SP, `RSF_CH_R,
      hexc({3'h0, radio_r.range_a[4]}),
      hexc(radio_r.range_a[3:0]),
      `RSF_CH_SP, `RSF_CH_G,
      hexc({3'h0, radio_r.range_b[4]}),
      hexc(radio_r.range_b[3:0]),
      `RSF_CH_SP, `RSF_CH_A, `RSF_CH_ZERO, hexc(radio_r.atten),
      `RSF_CH_SP, `RSF_CH_I, `RSF_CH_ZERO, hexc(radio_r.atten3),
      `RSF_CH_CR};
   wire [8*35-1:0] t527 = {
      rf_head,
      `RSF_CH_SP, `RSF_CH_F,
      hexc({3'h0, f_hund}),
      hexc(f_tens[3:0]),
      hexc(f_ones[3:0]),
      rf_tail};
   // legacy entry shows the raw value as two hex digits
   wire [8*34-1:0] t527l = {
      rf_head,
      `RSF_CH_SP, `RSF_CH_F,
      hexc({1'b0, radio_r.freq[6:4]}),
      hexc(radio_r.freq[3:0]),
      rf_tail};

   // presence reply
   wire [8*20-1:0] t529 = {
      `RSF_TAG_PRES,
      `RSF_CH_SP, `RSF_CH_P, hexc({3'h0, pres_r.no_tag}),
      `RSF_CH_SP, `RSF_CH_D, `RSF_CH_ZERO,
      `RSF_CH_SP, `RSF_CH_A, hexc({2'h0, pres_r.turnoff}),
      `RSF_CH_SP, `RSF_CH_T, hexc(pres_r.timeout),
      `RSF_CH_SP, `RSF_CH_I, hexc({3'h0, pres_r.invert}),
      `RSF_CH_CR};

   // id filter reply
   wire [8*11-1:0] t530 = {
      `RSF_TAG_FILTER,
      `RSF_CH_SP, `RSF_CH_U, hexc({1'b0, filter_r.sep}),
      `RSF_CH_SP, `RSF_CH_V, hexc({2'h0, filter_r.valid}),
      `RSF_CH_CR};

   // card-reader replies
   wire [8*6-1:0] t532 = {
      `RSF_TAG_CARD,
      `RSF_CH_SP, hexc({3'h0, card_r.en}),
      `RSF_CH_CR};
   wire [8*7-1:0] t533 = {
      `RSF_TAG_RETX,
      `RSF_CH_SP,
      hexc(card_r.interval[7:4]),
      hexc(card_r.interval[3:0]),
      `RSF_CH_CR};

   // command decode, replies left aligned in the buffer
   wire is522 = cmd_r == `RSF_CMD_SERIAL;
   wire is524 = cmd_r == `RSF_CMD_APPEND;
   wire is525 = cmd_r == `RSF_CMD_PROTO;
   wire is526 = cmd_r == `RSF_CMD_IO;
   wire is527 = cmd_r == `RSF_CMD_RADIO;
   wire is529 = cmd_r == `RSF_CMD_PRES;
   wire is530 = cmd_r == `RSF_CMD_FILTER;
   wire is532 = cmd_r == `RSF_CMD_CARD;
   wire is533 = cmd_r == `RSF_CMD_RETX;
   wire known = is522 | is524 | is525 | is526 | is527 | is529 | is530 | is532 | is533;
   wire legacy = radio_r.legacy;

   wire [BW-1:0] sel_vec =
      is522 ? {t522, {(BW-8*17){1'b0}}} :
      is524 ? {t524, {(BW-8*14){1'b0}}} :
      is525 ? {t525, {(BW-8*18){1'b0}}} :
      is526 ? {t526, {(BW-8*17){1'b0}}} :
      (is527 && !legacy) ? {t527, {(BW-8*35){1'b0}}} :
      is527 ? {t527l, {(BW-8*34){1'b0}}} :
      is529 ? {t529, {(BW-8*20){1'b0}}} :
      is530 ? {t530, {(BW-8*11){1'b0}}} :
      is532 ? {t532, {(BW-8*6){1'b0}}} :
      is533 ? {t533, {(BW-8*7){1'b0}}} :
      {BW{1'b0}};
   wire [5:0] sel_len =
      is522 ? `RSF_LEN_SERIAL :
      is524 ? `RSF_LEN_APPEND :
      is525 ? `RSF_LEN_PROTO :
      is526 ? `RSF_LEN_IO :
      (is527 && !legacy) ? `RSF_LEN_RADIO :
      is527 ? `RSF_LEN_RADIO_L :
      is529 ? `RSF_LEN_PRES :
      is530 ? `RSF_LEN_FILTER :
      is532 ? `RSF_LEN_CARD :
      is533 ? `RSF_LEN_RETX :
      6'h00;

   // a new command replaces any unread reply, so the host must drain first
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r  <= rsf_pkg::rsf_st_idle;
         cmd_r <= 16'h0000;
         buf_r <= {BW{1'b0}};
         len_r <= 6'h00;
         err_r <= 1'b0;
      end else begin
         unique case (st_r)
            rsf_pkg::rsf_st_idle: begin
               if (wr_commit && sel_cmd) begin
                  cmd_r <= writedata[15:0];
                  st_r  <= rsf_pkg::rsf_st_build;
               end else if (pop) begin
                  buf_r <= buf_r << 8;
                  len_r <= len_r - 6'h01;
               end
            end
            rsf_pkg::rsf_st_build: begin
               buf_r <= sel_vec;
               len_r <= sel_len;
               err_r <= ~known;
               st_r  <= rsf_pkg::rsf_st_idle;
            end
         endcase
      end
   end

   sequence s_build(logic [15:0] c);
      st_r == rsf_pkg::rsf_st_build && cmd_r == c;
   endsequence

   a_serial_len:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_build(`RSF_CMD_SERIAL) |=> len_r == 6'h11)
      else $error("serial reply length wrong");

   a_line_end_zero:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_build(`RSF_CMD_SERIAL) |=> buf_r[BW-1-112 -: 16] == 16'h4430)
      else $error("line-end delay field not D0");

   a_proto_off:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_build(`RSF_CMD_PROTO) ##0 proto_r.timeout == 8'hff
      |=> buf_r[BW-1-72 -: 16] == 16'h4646)
      else $error("disabled timeout not shown as FF");

   a_input_digit:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_build(`RSF_CMD_IO) |=> buf_r[BW-1-96 -: 8] == hexc({2'h0, $past(io_in)}))
      else $error("input state digit wrong");

   a_freq_width:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_build(`RSF_CMD_RADIO) |=> len_r == ($past(radio_r.legacy) ? 6'h22 : 6'h23))
      else $error("radio reply width wrong");

   a_pres_timeout:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_build(`RSF_CMD_PRES) |=> buf_r[BW-1-120 -: 8] == hexc($past(pres_r.timeout)))
      else $error("radio timeout digit wrong");

   a_bus_answer:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      (req && wait_r) |=> !wait_r ##1 wait_r)
      else $error("waitrequest not one cycle low");

   a_pop_count:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      pop && !(wr_commit && sel_cmd) |=> len_r == $past(len_r) - 6'h01)
      else $error("reply byte not consumed once");

   a_cmd_reply:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      (wr_commit && sel_cmd && st_r == rsf_pkg::rsf_st_idle)
      |=> st_r == rsf_pkg::rsf_st_build ##1 (st_r == rsf_pkg::rsf_st_idle && (err_r || len_r != 6'h00)))
      else $error("command did not yield one reply");

   // field checks look one cycle after the build, when the buffer holds the new text
   a_som_field:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_build(`RSF_CMD_PROTO) |=> buf_r[BW-1-120 -: 16] == 16'h5330)
      else $error("start-of-message field not S0");

   a_radio_state:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_build(`RSF_CMD_RADIO) |=> buf_r[BW-1-72 -: 8] == hexc({3'h0, $past(rf_on)}))
      else $error("radio state digit wrong");

   a_presence_d0:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_build(`RSF_CMD_PRES) |=> buf_r[BW-1-64 -: 16] == 16'h4430)
      else $error("presence period field not D0");

   a_card_digit:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_build(`RSF_CMD_CARD) |=> buf_r[BW-1-24 -: 16] == {8'h20, hexc({3'h0, $past(card_r.en)})})
      else $error("card output mode digit wrong");

   a_unknown_cmd:
   assert property (@(posedge sys_clk) disable iff (!reset_n)
      (st_r == rsf_pkg::rsf_st_build && !known) |=> err_r && len_r == 6'h00)
      else $error("unknown command left a reply");

endmodule

// ### bench/rsf_host_model.sv
// host model: avalon-mm master issuing one transfer at a time
// assumes sys_clk from the bench and a slave that answers by lowering waitrequest
`timescale 1ns/1ps
module rsf_host_model (
   input  wire logic        sys_clk,
   output logic      [7:0]  address,
   output logic             read,
   output logic             write,
   output logic      [31:0] writedata,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest
);
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
   end

   // a fresh edge before each request, so a release and a new raise never share a step
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      address   <= a;
      writedata <= d;
      write     <= 1'b1;
      do @(posedge sys_clk); while (waitrequest !== 1'b0);
      write     <= 1'b0;
      // released data no longer shows the last value
      writedata <= ~d;
   endtask

   task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      address <= a;
      read    <= 1'b1;
      do @(posedge sys_clk); while (waitrequest !== 1'b0);
      d = readdata;
      read    <= 1'b0;
   endtask
endmodule

// ### bench/tb.sv
// testbench: drives display commands and drains each reply byte by byte
// assumes the map header constants and the host model for all bus traffic
`timescale 1ns/1ps
`include "rsf_map.svh"
module tb;
   logic        sys_clk;
   logic        reset_n;
   logic [7:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [1:0]  io_in;
   logic        rf_on;
   logic [31:0] d;
   logic [31:0] rv [8];
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          cyc = 0;

   rsf_formatter #(.ML(36)) rsf_formatter_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .io_in(io_in), .rf_on(rf_on));

   rsf_host_model rsf_host_model_inst (
      .sys_clk(sys_clk), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      rsf_host_model_inst.bus_write(a, v);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      rsf_host_model_inst.bus_read(a, v);
   endtask

   // tag words may be three characters, so zero bytes are skipped
   function automatic string ts(input logic [31:0] t);
      ts = "";
      for (int i = 3; i >= 0; i--)
         if (t[i*8 +: 8] != 8'h00) ts = $sformatf("%s%c", ts, t[i*8 +: 8]);
   endfunction

   // set one register, issue a command, drain the whole reply, then expect nothing more
   task automatic tc(input logic [7:0] off, input logic [31:0] v, input logic [15:0] cmd,
                     input logic [2:0] inp, input string tg, input string sx);
      logic [31:0] x;
      string       s;
      s = {tg, sx};
      @(posedge sys_clk);
      {rf_on, io_in} <= inp;
      wr(off, v);
      rd(off, x);
      chk(x, v);
      wr(`RSF_OFF_CMD, {16'h0000, cmd});
      rd(`RSF_OFF_STATUS, x);
      chk(x, {26'h0, 6'(s.len() + 1)});
      for (int i = 0; i <= s.len(); i++) begin
         rd(`RSF_OFF_DATA, x);
         chk(x, {24'h0, (i < s.len()) ? s[i] : `RSF_CH_CR});
      end
      rd(`RSF_OFF_DATA, x);
      chk(x, 32'h0);
      rd(`RSF_OFF_STATUS, x);
      chk(x, 32'h0);
      $display("test %h done", cmd);
   endtask

   // ceiling well above the few thousand cycles the sequence needs
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   initial begin
      reset_n = 1'b0;
      io_in = 2'b00;
      rf_on = 1'b0;
      rv = '{32'(`RSF_RST_SERIAL), 32'(`RSF_RST_APPEND), 32'(`RSF_RST_PROTO),
             32'(`RSF_RST_IO), 32'(`RSF_RST_RADIO), 32'(`RSF_RST_PRES),
             32'(`RSF_RST_FILTER), 32'(`RSF_RST_CARD)};
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(8'(4 * i), d);
         chk(d, rv[i]);
      end
      wr(8'h30, 32'hffffffff);
      rd(8'h30, d);
      chk(d, 32'h0);
      wr(`RSF_OFF_CMD, 32'h0000_0210);
      rd(`RSF_OFF_STATUS, d);
      chk(d, 32'h40);
      rd(`RSF_OFF_CMD, d);
      chk(d, 32'h210);
      $display("test reset and refusals done");
      for (int b = 2; b < 8; b++)
         tc(`RSF_OFF_SERIAL, 32'(((b % 3) << 4) | ((b % 2) << 3) | b), `RSF_CMD_SERIAL, 3'b000,
            ts(`RSF_TAG_SERIAL), $sformatf(" B%0d S%0d P%0d D0", b, b % 2, b % 3));
      tc(`RSF_OFF_APPEND, 32'h5, `RSF_CMD_APPEND, 3'b000, ts(`RSF_TAG_APPEND), " T1 D0 X1");
      tc(`RSF_OFF_APPEND, 32'h2, `RSF_CMD_APPEND, 3'b000, ts(`RSF_TAG_APPEND), " T0 D1 X0");
      tc(`RSF_OFF_PROTO, 32'h8ea, `RSF_CMD_PROTO, 3'b000, ts(`RSF_TAG_PROTO),
         " P2 T3A X2 S0");
      tc(`RSF_OFF_PROTO, 32'h7fd, `RSF_CMD_PROTO, 3'b000, ts(`RSF_TAG_PROTO),
         " P1 TFF X1 S0");
      tc(`RSF_OFF_PROTO, 32'h0, `RSF_CMD_PROTO, 3'b000, ts(`RSF_TAG_PROTO),
         " P0 T00 X0 S0");
      for (int k = 0; k < 4; k++)
         tc(`RSF_OFF_IO, 32'((k << 3) | (k << 1) | (k & 1)), `RSF_CMD_IO, 3'(k), ts(`RSF_TAG_IO),
            $sformatf(" C%0d O%0d I%0d D%0X", k & 1, k, k, k));
      tc(`RSF_OFF_IO, 32'h7f, `RSF_CMD_IO, 3'b010, ts(`RSF_TAG_IO), " C1 O3 I2 DF");
      tc(`RSF_OFF_RADIO, 32'h1f45fbb7, `RSF_CMD_RADIO, 3'b100, ts(`RSF_TAG_RADIO),
         " C1 O1 T3 F118 R1F G05 A0A I0F");
      tc(`RSF_OFF_RADIO, 32'h554, `RSF_CMD_RADIO, 3'b000, ts(`RSF_TAG_RADIO),
         " C0 O0 T2 F2A R00 G00 A00 I00");
      tc(`RSF_OFF_RADIO, 32'h2, `RSF_CMD_RADIO, 3'b000, ts(`RSF_TAG_RADIO),
         " C0 O0 T1 F000 R00 G00 A00 I00");
      tc(`RSF_OFF_PRES, 32'h85, `RSF_CMD_PRES, 3'b000, ts(`RSF_TAG_PRES),
         " P1 D0 A2 T0 I1");
      tc(`RSF_OFF_PRES, 32'h72, `RSF_CMD_PRES, 3'b000, ts(`RSF_TAG_PRES),
         " P0 D0 A1 TE I0");
      tc(`RSF_OFF_PRES, 32'h78, `RSF_CMD_PRES, 3'b000, ts(`RSF_TAG_PRES),
         " P0 D0 A0 TF I0");
      for (int u = 0; u < 5; u++)
         tc(`RSF_OFF_FILTER, 32'(((u % 4) << 3) | u), `RSF_CMD_FILTER, 3'b000, ts(`RSF_TAG_FILTER),
            $sformatf(" U%0d V%0d", u, u % 4));
      tc(`RSF_OFF_CARD, 32'h1ff, `RSF_CMD_CARD, 3'b000, ts(`RSF_TAG_CARD), " 1");
      tc(`RSF_OFF_CARD, 32'h1ff, `RSF_CMD_RETX, 3'b000, ts(`RSF_TAG_RETX), " FF");
      tc(`RSF_OFF_CARD, 32'h002, `RSF_CMD_CARD, 3'b000, ts(`RSF_TAG_CARD), " 0");
      tc(`RSF_OFF_CARD, 32'h002, `RSF_CMD_RETX, 3'b000, ts(`RSF_TAG_RETX), " 01");
      print_verdict();
   end
endmodule
